// File: logic/haptic_readout_map.svh
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: Serial control port with 7-bit addressing
// Notes: Definitions only
`ifndef HAPTIC_READOUT_MAP_SVH
`define HAPTIC_READOUT_MAP_SVH

`define REG_ACTUATOR_IMPEDANCE 8'h03
`define REG_SUPPLY_VOLTAGE 8'h04
`define REG_PERIOD_HIGH 8'h05
`define REG_PERIOD_LOW 8'h06
`define REG_DRIVE_CONTROL 8'h07

`define RESET_MEASUREMENT 8'h00
`define RESET_DRIVE_CONTROL 8'h44
`define UNMAPPED_READ 8'h00

`define FIELD_BCAST_BIT 7
`define FIELD_AVG_DIS_BIT 6
`define FIELD_COMP_HI 5
`define FIELD_COMP_LO 4
`define FIELD_TRIG_HI 3
`define FIELD_TRIG_LO 2
`define FIELD_MODE_HI 1
`define FIELD_MODE_LO 0
`define PERIOD_HIGH_BITS 2

`define BROADCAST_ADDRESS 7'h58
`define PERIOD_AVG_DEPTH 4

// Period in ns = count * step
`define PERIOD_STEP_NS 24390
`define SYS_CLK_PERIOD_NS 40

`endif

// File: logic/haptic_readout_pkg.sv
// Purpose: Shared types of the measurement readout block
// Assumes: Constants live in haptic_readout_map.svh
// Notes: Types only
package haptic_readout_pkg;

    typedef enum logic [1:0] {
        MODE_REALTIME_PLAYBACK,
        MODE_SEQUENCER,
        MODE_DIAGNOSTICS,
        MODE_CALIBRATION
    } op_mode_t;

    typedef enum logic [1:0] {
        TRIG_PULSE_INPUT,
        TRIG_LEVEL_INPUT,
        TRIG_INTERRUPT_OUTPUT,
        TRIG_RESERVED
    } trig_func_t;

    typedef struct packed {
        logic broadcast_respond_enable;
        logic period_averaging_disable;
        logic [1:0] regulator_compensation_select;
        trig_func_t trigger_pin_function;
        op_mode_t mode;
    } drive_control_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } serial_state_t;

endpackage

// File: logic/period_if.sv
// Purpose: Carries period samples, lock requests and result
// Assumes: Single clock domain
// Notes: regs side drives requests, capture side drives result
`timescale 1ns/10ps
interface period_if;
    logic playing;
    logic braking;
    logic sample_valid;
    logic [9:0] sample;
    logic averaging_disable;
    logic lock_request;
    logic unlock_request;
    logic [9:0] period;
    logic locked;

    modport regs (
        output playing, braking, sample_valid, sample,
        output averaging_disable, lock_request, unlock_request,
        input period, locked
    );
    modport capture (
        input playing, braking, sample_valid, sample,
        input averaging_disable, lock_request, unlock_request,
        output period, locked
    );
endinterface

// File: logic/period_capture.sv
// Purpose: Resonance period averaging and coherent read lock
// Assumes: Samples arrive as one-cycle strobes from the drive engine
// Notes: History is cleared at each playback start
`timescale 1ns/10ps
`include "haptic_readout_map.svh"
module period_capture (
    input wire logic i_clk,
    input wire logic i_reset_n,
    period_if.capture bus
);
    import haptic_readout_pkg::*;

    logic [9:0] history [`PERIOD_AVG_DEPTH];
    logic playing_q;
    logic [9:0] next_period;

    function automatic logic [9:0] average4(
        input logic [9:0] a, b, c, d);
        logic [11:0] sum;
        sum = 12'(a) + 12'(b) + 12'(c) + 12'(d);
        return sum[11:2];
    endfunction

    wire playback_start = bus.playing & ~playing_q;
    wire playback_end = ~bus.playing & playing_q;
    // Braking samples are unreliable, so they never enter the history
    wire take_sample = bus.sample_valid & bus.playing & ~bus.braking;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            playing_q <= 1'b0;
        end else begin
            playing_q <= bus.playing;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < `PERIOD_AVG_DEPTH; i++) begin
                history[i] <= 10'h000;
            end
        end else if (playback_start) begin
            for (int i = 0; i < `PERIOD_AVG_DEPTH; i++) begin
                history[i] <= 10'h000;
            end
        end else if (take_sample) begin
            history[0] <= bus.sample;
            for (int i = 1; i < `PERIOD_AVG_DEPTH; i++) begin
                history[i] <= history[i-1];
            end
        end
    end

    always_comb begin
        if (bus.averaging_disable) begin
            next_period = history[0];
        end else begin
            next_period = average4(history[0], history[1],
                history[2], history[3]);
        end
    end

    // Lock: set by the upper byte read, cleared by lower read or end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.locked <= 1'b0;
        end else if (bus.lock_request) begin
            bus.locked <= 1'b1;
        end else if (bus.unlock_request || playback_end) begin
            bus.locked <= 1'b0;
        end
    end

    // Reported count follows the history only while playing and unlocked
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus.period <= 10'h000;
        end else if (bus.playing && !bus.locked && !bus.lock_request) begin
            bus.period <= next_period;
        end
    end

endmodule // period_capture

// File: logic/haptic_measurement_readout_regs.sv
// Purpose: Measurement readout registers behind the serial control port
// Assumes: Open-drain data line, clock line as plain input, both async
// Notes: Pointer auto-increments after each data byte
// Operation
// - Impedance result at 0x03 loads on diagnostics done; resets zero
// - Supply voltage reading at 0x04, live, resets zero
// - Supply reading refreshes only while a waveform plays
// - Ten-bit period: high two bits at 0x05, low byte 0x06
// - Upper byte read freezes both bytes until lower byte read
// - Playback end releases an unfinished freeze automatically
// - Period equals count times a 24.39 us step
// - Period samples taken during braking are not trusted
// - Mode field bits 1-0 of drive_control_config; change mid-process forces standby
// - Trigger pin function bits 3-2; change mid-process forces standby
// - Averaging off reports last period, else mean of four
// - Broadcast enable makes the device answer address 0x58 too
`timescale 1ns/10ps
`include "haptic_readout_map.svh"
module haptic_measurement_readout_regs #(
    // Arbitrary device address
    parameter logic [6:0] DEVICE_ADDRESS = 7'h2A
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic I_DIAG_DONE,
    input wire logic [7:0] I_DIAG_IMPEDANCE,
    input wire logic I_SUPPLY_VALID,
    input wire logic [7:0] I_SUPPLY_SAMPLE,
    input wire logic I_PLAYING,
    input wire logic I_BRAKING,
    input wire logic I_PERIOD_VALID,
    input wire logic [9:0] I_PERIOD_SAMPLE,
    input wire logic I_PROCESS_ACTIVE,
    output logic O_SDA_O,
    output logic O_SDA_OE,
    output haptic_readout_pkg::op_mode_t O_MODE,
    output haptic_readout_pkg::trig_func_t O_TRIGGER_PIN_FUNCTION,
    output logic O_PERIOD_AVERAGING_DISABLE,
    output logic [1:0] O_REGULATOR_COMPENSATION_SELECT,
    output logic O_BROADCAST_RESPOND_ENABLE,
    output logic O_FORCE_STANDBY,
    output logic [9:0] O_RESONANCE_PERIOD_COUNT
);
    import haptic_readout_pkg::*;

    period_if pif ();

    logic scl_s1, scl_s2, scl_q;
    logic sda_s1, sda_s2, sda_q;
    serial_state_t state;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [2:0] bit_cnt;
    logic [7:0] ptr;
    logic rw_read;
    logic phase;
    logic nack;
    logic [7:0] actuator_impedance;
    logic [7:0] supply_voltage_reading;
    drive_control_t drive_control_config;
    logic [7:0] rx_byte;
    logic wr_stb;
    logic rd_stb;

    // Clock line is sampled, not used as a clock
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_q <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s1 <= I_SCL;
            scl_s2 <= scl_s1;
            scl_q <= scl_s2;
            sda_s1 <= I_SDA;
            sda_s2 <= sda_s1;
            sda_q <= sda_s2;
        end
    end

    wire scl_rise = scl_s2 & ~scl_q;
    wire scl_fall = ~scl_s2 & scl_q;
    wire start_cond = scl_s2 & scl_q & sda_q & ~sda_s2;
    wire stop_cond = scl_s2 & scl_q & ~sda_q & sda_s2;

    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input logic [7:0] imp,
        input logic [7:0] sup,
        input logic [9:0] per,
        input drive_control_t ctl);
        logic [7:0] value;
        unique case (addr)
            `REG_ACTUATOR_IMPEDANCE: value = imp;
            `REG_SUPPLY_VOLTAGE: value = sup;
            `REG_PERIOD_HIGH: value = {6'h00, per[9:8]};
            `REG_PERIOD_LOW: value = per[7:0];
            `REG_DRIVE_CONTROL: value = ctl;
            default: value = `UNMAPPED_READ;
        endcase
        return value;
    endfunction

    function automatic logic addr_match(
        input logic [6:0] addr,
        input logic bcast);
        return (addr == DEVICE_ADDRESS) ||
            (bcast && addr == `BROADCAST_ADDRESS);
    endfunction

    assign rx_byte = {shreg[6:0], sda_s2};
    wire [7:0] rd_value = read_mux(ptr, actuator_impedance,
        supply_voltage_reading, pif.period, drive_control_config);
    // A byte leaves the register file when its first bit is driven
    assign rd_stb = scl_fall && phase &&
        ((state == ST_ADDR_ACK && rw_read) ||
         (state == ST_RDATA_ACK && !nack));
    assign wr_stb = scl_rise && state == ST_WDATA && bit_cnt == 3'd7;

    // Serial protocol sequencing
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 3'd0;
            rw_read <= 1'b0;
            phase <= 1'b0;
            nack <= 1'b0;
        end else if (start_cond) begin
            state <= ST_ADDR;
            bit_cnt <= 3'd0;
            phase <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
        end else begin
            if (scl_rise) begin
                shreg <= rx_byte;
                bit_cnt <= bit_cnt + 3'd1;
            end
            unique case (state)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (scl_rise && bit_cnt == 3'd7) begin
                        if (addr_match(rx_byte[7:1],
                                drive_control_config
                                .broadcast_respond_enable)) begin
                            rw_read <= rx_byte[0];
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_PTR, ST_WDATA: begin
                    if (scl_rise && bit_cnt == 3'd7) begin
                        state <= (state == ST_PTR) ? ST_PTR_ACK
                            : ST_WDATA_ACK;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise && bit_cnt == 3'd7) begin
                        state <= ST_RDATA_ACK;
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        phase <= ~phase;
                        if (phase) begin
                            bit_cnt <= 3'd0;
                            if (state == ST_ADDR_ACK && rw_read) begin
                                state <= ST_RDATA;
                            end else if (state == ST_ADDR_ACK) begin
                                state <= ST_PTR;
                            end else begin
                                state <= ST_WDATA;
                            end
                        end
                    end
                    if (scl_rise) begin
                        bit_cnt <= 3'd0;
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        nack <= sda_s2;
                        bit_cnt <= 3'd0;
                    end
                    if (scl_fall) begin
                        phase <= ~phase;
                        if (phase) begin
                            state <= nack ? ST_IDLE : ST_RDATA;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Open-drain data line: only ever pulled low
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_SDA_O <= 1'b0;
            O_SDA_OE <= 1'b0;
            tx <= 8'h00;
        end else if (start_cond || stop_cond) begin
            O_SDA_OE <= 1'b0;
        end else if (scl_fall) begin
            if (rd_stb) begin
                tx <= {rd_value[6:0], 1'b0};
                O_SDA_OE <= ~rd_value[7];
            end else if (state == ST_RDATA) begin
                O_SDA_OE <= (bit_cnt == 3'd0) ? 1'b0 : ~tx[7];
                tx <= {tx[6:0], 1'b0};
            end else if ((state == ST_ADDR_ACK || state == ST_PTR_ACK ||
                    state == ST_WDATA_ACK) && !phase) begin
                O_SDA_OE <= 1'b1;
            end else begin
                O_SDA_OE <= 1'b0;
            end
        end
    end

    // Register pointer, advanced after every data byte
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ptr <= 8'h00;
        end else if (scl_rise && state == ST_PTR && bit_cnt == 3'd7) begin
            ptr <= rx_byte;
        end else if (wr_stb || rd_stb) begin
            ptr <= ptr + 8'h01;
        end
    end

    // Only the control register accepts writes
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            drive_control_config <= `RESET_DRIVE_CONTROL;
        end else if (wr_stb && ptr == `REG_DRIVE_CONTROL) begin
            drive_control_config <= rx_byte;
        end
    end

    // Standby on mode or pin function change while a process runs
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_FORCE_STANDBY <= 1'b0;
        end else begin
            O_FORCE_STANDBY <= wr_stb && ptr == `REG_DRIVE_CONTROL &&
                I_PROCESS_ACTIVE &&
                ((rx_byte[`FIELD_MODE_HI:`FIELD_MODE_LO] !=
                    drive_control_config.mode) ||
                 (rx_byte[`FIELD_TRIG_HI:`FIELD_TRIG_LO] !=
                    drive_control_config.trigger_pin_function));
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            actuator_impedance <= `RESET_MEASUREMENT;
        end else if (I_DIAG_DONE) begin
            actuator_impedance <= I_DIAG_IMPEDANCE;
        end
    end

    // Sampling happens only while a waveform plays
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            supply_voltage_reading <= `RESET_MEASUREMENT;
        end else if (I_SUPPLY_VALID && I_PLAYING) begin
            supply_voltage_reading <= I_SUPPLY_SAMPLE;
        end
    end

    // Lock requests come from the byte load, so a host that never
    // finishes the pair is rescued at playback end
    assign pif.playing = I_PLAYING;
    assign pif.braking = I_BRAKING;
    assign pif.sample_valid = I_PERIOD_VALID;
    assign pif.sample = I_PERIOD_SAMPLE;
    assign pif.averaging_disable =
        drive_control_config.period_averaging_disable;
    assign pif.lock_request = rd_stb && ptr == `REG_PERIOD_HIGH;
    assign pif.unlock_request = rd_stb && ptr == `REG_PERIOD_LOW;

    period_capture u_period_capture (
        .i_clk(I_SYS_CLK),
        .i_reset_n(I_RESET_N),
        .bus(pif.capture)
    );

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_MODE <= MODE_REALTIME_PLAYBACK;
            O_TRIGGER_PIN_FUNCTION <= TRIG_LEVEL_INPUT;
            O_PERIOD_AVERAGING_DISABLE <= 1'b1;
            O_REGULATOR_COMPENSATION_SELECT <= 2'h0;
            O_BROADCAST_RESPOND_ENABLE <= 1'b0;
            O_RESONANCE_PERIOD_COUNT <= 10'h000;
        end else begin
            O_MODE <= drive_control_config.mode;
            O_TRIGGER_PIN_FUNCTION <=
                drive_control_config.trigger_pin_function;
            O_PERIOD_AVERAGING_DISABLE <=
                drive_control_config.period_averaging_disable;
            O_REGULATOR_COMPENSATION_SELECT <=
                drive_control_config.regulator_compensation_select;
            O_BROADCAST_RESPOND_ENABLE <=
                drive_control_config.broadcast_respond_enable;
            // Count times the fixed step gives the actuator period
            O_RESONANCE_PERIOD_COUNT <= pif.period;
        end
    end

endmodule // haptic_measurement_readout_regs

// File: verification/haptic_readout_props.sv
// Purpose: Port assertions of the measurement readout registers
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/10ps
module haptic_readout_props (
    input logic I_SYS_CLK,
    input logic I_RESET_N,
    input logic I_SCL,
    input logic I_PLAYING,
    input logic I_BRAKING,
    input logic I_PROCESS_ACTIVE,
    input logic O_SDA_O,
    input logic O_SDA_OE,
    input haptic_readout_pkg::op_mode_t O_MODE,
    input haptic_readout_pkg::trig_func_t O_TRIGGER_PIN_FUNCTION,
    input logic O_PERIOD_AVERAGING_DISABLE,
    input logic [1:0] O_REGULATOR_COMPENSATION_SELECT,
    input logic O_BROADCAST_RESPOND_ENABLE,
    input logic O_FORCE_STANDBY,
    input logic [9:0] O_RESONANCE_PERIOD_COUNT
);
    import haptic_readout_pkg::*;
    logic [7:0] cfg;
    assign cfg = {O_BROADCAST_RESPOND_ENABLE, O_PERIOD_AVERAGING_DISABLE,
        O_REGULATOR_COMPENSATION_SELECT, O_TRIGGER_PIN_FUNCTION, O_MODE};
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Run lengths cover the sample-to-output pipeline
    sequence idle_run;
        (!I_PLAYING)[*5];
    endsequence
    sequence brake_run;
        (I_PLAYING && I_BRAKING)[*6];
    endsequence
    chk_reset_values: assert property ($rose(I_RESET_N) |->
        cfg == 8'h44 && O_RESONANCE_PERIOD_COUNT == 10'h000 && !O_SDA_OE)
        else $error("values after reset wrong");
    chk_sda_drive: assert property (O_SDA_O == 1'b0)
        else $error("data line drive value not low");
    chk_ack_timing: assert property ($changed(O_SDA_OE) |->
        !I_SCL && !$past(I_SCL, 2)) else $error("data changed, clock high");
    chk_cfg_source: assert property ($changed(cfg) |->
        $past(I_SCL, 2) || $past(I_SCL, 4) || $past(I_SCL, 6))
        else $error("control fields changed without a bus write");
    chk_standby_width: assert property (O_FORCE_STANDBY |=>
        !O_FORCE_STANDBY) else $error("standby pulse too long");
    chk_standby_cause: assert property (O_FORCE_STANDBY |->
        $past(I_PROCESS_ACTIVE) || $past(I_PROCESS_ACTIVE, 2))
        else $error("standby without a running process");
    chk_idle_hold: assert property (idle_run |->
        $stable(O_RESONANCE_PERIOD_COUNT)) else $error("period moved idle");
    chk_brake_hold: assert property (brake_run |->
        $stable(O_RESONANCE_PERIOD_COUNT)) else $error("period moved brake");
endmodule // haptic_readout_props

// File: verification/haptic_host_model.sv
// Purpose: Host on the serial control bus
// Assumes: Data line pulled up; clock idles high outside frames
// Notes: Half bit of eight clocks, above the four the device needs
`timescale 1ns/10ps
module haptic_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge i_clk);
    endtask
    // Data moves two clocks after the clock falls; after a start condition the first bit moves with the fall
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= !b;
        half();
        o_scl <= 1'b1;
        half();
        r = i_sda;
        o_scl <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic byte_io(input logic [7:0] t, input logic a_in,
            output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(t[i], r[i]);
        end
        bit_io(a_in, a);
    endtask
    task automatic cond(input logic stop);
        o_sda_low <= stop;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= !stop;
        half();
        o_scl <= stop;
    endtask
    task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr,
            input int n, input logic [7:0] wd, output logic [7:0] q[$],
            output logic nak);
        logic [7:0] b;
        logic a;
        q = {};
        cond(1'b0);
        byte_io({dev, 1'b0}, 1'b1, b, nak);
        byte_io(ptr, 1'b1, b, a);
        if (n == 0) begin
            byte_io(wd, 1'b1, b, a);
        end else begin
            cond(1'b0);
            byte_io({dev, 1'b1}, 1'b1, b, a);
            for (int i = 0; i < n; i++) begin
                byte_io(8'hFF, i == n - 1, b, a);
                q.push_back(b);
            end
        end
        cond(1'b1);
    endtask
endmodule // haptic_host_model

// File: verification/haptic_measurement_readout_regs_test.sv
// Purpose: Self-checking bench of the measurement readout registers
// Assumes: Host model owns the bus, bench drives the engine inputs
// Notes: Fixed seed; model tracks lock state and period history
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
    bad_count++; $display("MISMATCH %0t %s", $time, m); end end
bind haptic_measurement_readout_regs haptic_readout_props props_u (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_SCL(I_SCL),
    .I_PLAYING(I_PLAYING), .I_BRAKING(I_BRAKING),
    .I_PROCESS_ACTIVE(I_PROCESS_ACTIVE), .O_SDA_O(O_SDA_O),
    .O_SDA_OE(O_SDA_OE), .O_MODE(O_MODE),
    .O_TRIGGER_PIN_FUNCTION(O_TRIGGER_PIN_FUNCTION),
    .O_PERIOD_AVERAGING_DISABLE(O_PERIOD_AVERAGING_DISABLE),
    .O_REGULATOR_COMPENSATION_SELECT(O_REGULATOR_COMPENSATION_SELECT),
    .O_BROADCAST_RESPOND_ENABLE(O_BROADCAST_RESPOND_ENABLE),
    .O_FORCE_STANDBY(O_FORCE_STANDBY),
    .O_RESONANCE_PERIOD_COUNT(O_RESONANCE_PERIOD_COUNT));
module haptic_measurement_readout_regs_test;
    import haptic_readout_pkg::*;
    localparam logic [6:0] ADDR = 7'h2A;
    logic clk = 1'b0, rst_n = 1'b0, dv = 1'b0, sv = 1'b0, pv = 1'b0;
    logic play = 1'b0, brk = 1'b0, proc = 1'b0, locked = 1'b0, nak;
    logic [7:0] dimp = 8'h00, ssmp = 8'h00, mimp = 8'h00, msup = 8'h00;
    logic [7:0] mctl = 8'h44;
    logic [9:0] psmp = 10'h000, mlive = 10'h000, mper = 10'h000, cnt;
    logic [7:0] q[$];
    int hist[$] = '{0, 0, 0, 0};
    int bad_count = 0, n_checks = 0, sb_n = 0, exp_sb = 0;
    int seed = 32'h100A;
    logic [31:0] r;
    logic scl, sda_low, sda_o, oe, avg, bc, sb;
    logic [1:0] comp;
    op_mode_t mode;
    trig_func_t trig;
    wire sda = !(sda_low || oe);
    haptic_host_model host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));
    haptic_measurement_readout_regs #(.DEVICE_ADDRESS(ADDR)) dut_u (
        .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_SCL(scl), .I_SDA(sda),
        .I_DIAG_DONE(dv), .I_DIAG_IMPEDANCE(dimp), .I_SUPPLY_VALID(sv),
        .I_SUPPLY_SAMPLE(ssmp), .I_PLAYING(play), .I_BRAKING(brk),
        .I_PERIOD_VALID(pv), .I_PERIOD_SAMPLE(psmp),
        .I_PROCESS_ACTIVE(proc), .O_SDA_O(sda_o), .O_SDA_OE(oe),
        .O_MODE(mode), .O_TRIGGER_PIN_FUNCTION(trig),
        .O_PERIOD_AVERAGING_DISABLE(avg),
        .O_REGULATOR_COMPENSATION_SELECT(comp),
        .O_BROADCAST_RESPOND_ENABLE(bc), .O_FORCE_STANDBY(sb),
        .O_RESONANCE_PERIOD_COUNT(cnt));
    initial forever #20 clk = ~clk;
    // Counted on the falling edge, clear of the bench's own updates
    always @(negedge clk) if (sb === 1'b1) sb_n++;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [7:0] exp_reg(input logic [7:0] p);
        case (p)
            8'h03: return mimp;
            8'h04: return msup;
            8'h05: return {6'h00, mper[9:8]};
            8'h06: return mper[7:0];
            8'h07: return mctl;
            default: return 8'h00;
        endcase
    endfunction
    task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n);
        logic [7:0] k;
        host_u.xfer(a, p, n, 8'h00, q, nak);
        for (int i = 0; i < n; i++) begin
            k = p + 8'(i);
            `CHK(q[i], exp_reg(k), "read data")
            if (k == 8'h05) locked = 1'b1;
            if (k == 8'h06 && play) mper = mlive;
            if (k == 8'h06) locked = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host_u.xfer(ADDR, p, 0, d, q, nak);
        `CHK(nak, 1'b0, "address ack")
        if (p == 8'h07 && proc && d[3:0] != mctl[3:0]) exp_sb++;
        if (p == 8'h07) mctl = d;
        tick(4);
        `CHK({bc, avg, comp, trig, mode}, mctl, "control")
        `CHK(sb_n, exp_sb, "standby")
    endtask
    task automatic per(input logic [9:0] v);
        int s;
        pv <= 1'b1;
        psmp <= v;
        tick(1);
        pv <= 1'b0;
        tick(4);
        if (play && !brk) begin
            hist.push_front(int'(v));
            void'(hist.pop_back());
            s = hist[0] + hist[1] + hist[2] + hist[3];
            mlive = mctl[6] ? v : 10'(s >> 2);
            if (!locked) mper = mlive;
        end
        `CHK(cnt, mper, "period")
    endtask
    task automatic set_play(input logic p);
        play <= p;
        tick(6);
        locked = locked && p;
        hist = '{0, 0, 0, 0};
        mlive = p ? 10'h000 : mlive;
        if (!locked && p) mper = mlive;
    endtask
    task automatic meas(input logic [7:0] v);
        dv <= 1'b1;
        dimp <= v;
        sv <= 1'b1;
        ssmp <= ~v;
        tick(1);
        dv <= 1'b0;
        sv <= 1'b0;
        mimp = v;
        if (play) msup = ~v;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        tick(100000);
        bad_count++;
        stop_test();
    end
    initial begin
        tick(16);
        rst_n <= 1'b1;
        tick(4);
        rd(ADDR, 8'h03, 5);
        rd(ADDR, 8'h20, 1);
        r = $random(seed);
        meas(r[7:0]);
        set_play(1'b1);
        meas(r[15:8]);
        rd(ADDR, 8'h03, 2);
        wr(8'h03, 8'h5A);
        wr(8'h06, 8'hA5);
        rd(ADDR, 8'h03, 4);
        per(r[25:16]);
        rd(ADDR, 8'h05, 1);
        per(~r[25:16]);
        rd(ADDR, 8'h06, 1);
        brk <= 1'b1;
        tick(2);
        per(r[9:0]);
        brk <= 1'b0;
        wr(8'h07, 8'h04);
        set_play(1'b0);
        set_play(1'b1);
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            per(r[9:0]);
        end
        rd(ADDR, 8'h05, 2);
        rd(ADDR, 8'h05, 1);
        set_play(1'b0);
        set_play(1'b1);
        per(r[19:10]);
        rd(ADDR, 8'h06, 1);
        proc <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            wr(8'h07, {2'b00, r[5:4], i[3:0]});
        end
        wr(8'h07, {2'b00, ~r[5:4], 4'hF});
        proc <= 1'b0;
        wr(8'h07, 8'h00);
        host_u.xfer(7'h58, 8'h07, 1, 8'h00, q, nak);
        `CHK(nak, 1'b1, "broadcast off")
        wr(8'h07, 8'h84);
        rd(7'h58, 8'h07, 1);
        `CHK(nak, 1'b0, "broadcast on")
        stop_test();
    end
endmodule // haptic_measurement_readout_regs_test
